// *** verilog/strap_pkg.sv ***
// constants for the port strap and debug pin block
package strap_pkg;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_STRAP_STATUS = 8'h00;
  localparam logic [7:0] OFS_GPIO_OE = 8'h04;
  localparam logic [7:0] OFS_GPIO_OUT = 8'h08;
  localparam logic [7:0] OFS_GPIO_IN = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_SMB_ADDR = 8'h14;
  localparam logic [7:0] OFS_DEBUG_SEL = 8'h18;
  localparam logic [7:0] OFS_PORT_STATUS = 8'h1C;

  // ************************************************************
  // strap status fields
  // ************************************************************
  localparam int ST_PRESENT_LSB = 0;
  localparam int ST_REFCLK = 2;
  localparam int ST_SLOT_LSB = 3;
  localparam int ST_PWR_SAVE = 5;
  localparam int ST_DEBUG = 6;
  localparam int ST_PSO_EN = 7;
  localparam int ST_MFG_TEST = 8;

  // ************************************************************
  // control register fields
  // ************************************************************
  localparam int CT_SMB_EN = 0;
  localparam int CT_EE_ACTIVE = 1;
  localparam int CT_EE_DATA = 2;
  localparam int CT_EE_RELEASE = 3;
  localparam int CT_EE_PIN = 4;
  localparam int CT_EE_CLK = 5;

  // ************************************************************
  // gpio field positions
  // ************************************************************
  localparam int GP_SMB_LSB = 5;
  localparam int GP_DBG_W = 5;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [7:0] GPIO_OE_RESET = 8'h00;
  localparam logic [7:0] GPIO_OUT_RESET = 8'h00;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int EE_HALF_NS = 5000;
  localparam int EE_HALF_CYC = EE_HALF_NS / CLK_PERIOD_NS;

endpackage

// *** verilog/sync_2ff.sv ***
// two flip-flop synchroniser bank
module sync_2ff #(
  parameter int W = 1
) (
  // clock
  input logic clk,
  // asynchronous levels and their synchronised copies
  input logic [W-1:0] async_lvl,
  output logic [W-1:0] sync_lvl
);

  logic [W-1:0] meta_q;

  // ************************************************************
  // two stages, no reset so straps pass during reset
  // ************************************************************
  always_ff @(posedge clk) begin
    meta_q <= async_lvl;
    sync_lvl <= meta_q;
  end

endmodule

// *** verilog/eeprom_pins.sv ***
// eeprom clock divider and data pin driver
module eeprom_pins (
  // clock and reset
  input logic clk,
  input logic rstn,
  // control from register file
  input logic active,
  input logic data_bit,
  input logic release_line,
  // pin side
  output logic eeprom_clk,
  output logic sdio_drv,
  output logic sdio_oe_n
);

  localparam logic [15:0] HALF_LAST =
    16'(strap_pkg::EE_HALF_CYC - 1);

  logic [15:0] div_q;

  // ************************************************************
  // clock sourced here, idle low between transfers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rstn || !active) begin
      div_q <= 16'h0000;
      eeprom_clk <= 1'b0;
    end else if (div_q == HALF_LAST) begin
      div_q <= 16'h0000;
      eeprom_clk <= ~eeprom_clk;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // ************************************************************
  // data line driven high unless a transfer uses it
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sdio_drv <= 1'b1;
      sdio_oe_n <= 1'b0;
    end else if (active) begin
      sdio_drv <= data_bit;
      sdio_oe_n <= release_line;
    end else begin
      sdio_drv <= 1'b1;
      sdio_oe_n <= 1'b0;
    end
  end

endmodule

// *** verilog/port_strap_debug_config.sv ***
// strap capture, debug pins and gpio control with wishbone registers
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.

// Function
// - presence low means device in slot
// - shared clock strap high reports platform clock
// - slot implemented high means port has slot
// - three port status outputs, one per port
// - eeprom clock is sourced as an output
// - eeprom data bidirectional, idles at one
// - scan enable driven zero in normal use
// - scan enable becomes input in test
// - gpio output enable register sets direction
// - gpio 7 to 5 give smbus address
// - gpio 4 to 0 select debug mode
// - power saving strap high enables saving
// - power saving strap low keeps it off
// - fourth test pin gates status in debug
// - first test pin low enters debug mode
module port_strap_debug_config (
  // clock and reset
  input logic clk,
  input logic rstn,
  // wishbone slave
  input logic wb_cyc,
  input logic wb_stb,
  input logic wb_we,
  input logic [7:0] wb_adr,
  input logic [31:0] wb_dat_w,
  input logic [3:0] wb_sel,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // strap pins
  input logic [2:1] slot_presence_n,
  input logic shared_refclk_sel,
  input logic [2:1] slot_implemented,
  input logic power_saving_strap,
  input logic port_state_out_enable,
  input logic debug_mode_enable_n,
  input logic mfg_test_mode,
  // port status from the switch core
  input logic [2:0] link_status,
  // decoded configuration
  output logic [2:1] device_present,
  output logic refclk_shared,
  output logic [2:1] slot_connected,
  output logic power_saving_en,
  output logic debug_mode,
  output logic [2:0] smbus_addr_low,
  output logic [4:0] debug_select,
  output logic scan_en_sample,
  // port status pins
  output logic [2:0] port_status,
  // eeprom pins
  output logic eeprom_clk,
  input logic eeprom_sdio_pin,
  output logic eeprom_sdio_drv,
  output logic eeprom_sdio_oe_n,
  // full scan enable pin
  input logic scan_en_pin,
  output logic scan_en_drv,
  output logic scan_en_oe_n,
  // general purpose pins
  input logic [7:0] gpio_pin,
  output logic [7:0] gpio_drv,
  output logic [7:0] gpio_oe_n
);

  // ************************************************************
  // functions
  // ************************************************************
  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h00_0000, b};
  endfunction

  function automatic logic [7:0] merge_byte(
    input logic [7:0] old_v,
    input logic [7:0] new_v,
    input logic lane
  );
    merge_byte = lane ? new_v : old_v;
  endfunction

  // ************************************************************
  // synchronisers
  // ************************************************************
  logic [8:0] strap_raw;
  logic [8:0] strap_sync;
  logic [9:0] pin_raw;
  logic [9:0] pin_sync;
  logic [7:0] gpio_sync;
  logic sdio_sync;
  logic scan_sync;

  assign strap_raw = {mfg_test_mode, debug_mode_enable_n,
    port_state_out_enable, power_saving_strap, slot_implemented,
    shared_refclk_sel, slot_presence_n};
  assign pin_raw = {scan_en_pin, eeprom_sdio_pin, gpio_pin};

  sync_2ff #(.W(9)) u_strap_sync (
    .clk(clk),
    .async_lvl(strap_raw),
    .sync_lvl(strap_sync)
  );

  sync_2ff #(.W(10)) u_pin_sync (
    .clk(clk),
    .async_lvl(pin_raw),
    .sync_lvl(pin_sync)
  );

  assign gpio_sync = pin_sync[7:0];
  assign sdio_sync = pin_sync[8];
  assign scan_sync = pin_sync[9];

  // ************************************************************
  // strap capture at reset release
  // ************************************************************
  logic captured_q;
  logic [2:1] present_n_q;
  logic refclk_q;
  logic [2:1] slot_impl_q;
  logic power_saving_strap_q;
  logic pso_en_q;
  logic dbg_n_q;
  logic mfg_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      captured_q <= 1'b0;
      present_n_q <= 2'b11;
      refclk_q <= 1'b0;
      slot_impl_q <= 2'b00;
      power_saving_strap_q <= 1'b0;
      pso_en_q <= 1'b0;
      dbg_n_q <= 1'b1;
      mfg_q <= 1'b0;
    end else if (!captured_q) begin
      captured_q <= 1'b1;
      present_n_q <= strap_sync[1:0];
      refclk_q <= strap_sync[2];
      slot_impl_q <= strap_sync[4:3];
      power_saving_strap_q <= strap_sync[5];
      pso_en_q <= strap_sync[6];
      dbg_n_q <= strap_sync[7];
      mfg_q <= strap_sync[8];
    end
  end

  // ************************************************************
  // strap decode
  // ************************************************************
  assign device_present = ~present_n_q;
  assign refclk_shared = refclk_q;
  assign slot_connected = slot_impl_q;
  assign power_saving_en = power_saving_strap_q;
  assign debug_mode = captured_q & ~dbg_n_q;

  // ************************************************************
  // control registers
  // ************************************************************
  logic [3:0] ctrl_q;
  logic [7:0] gpio_oe_q;
  logic [7:0] gpio_out_q;
  logic wr_en;
  logic rd_en;

  assign wr_en = wb_cyc & wb_stb & wb_we & ~wb_ack;
  assign rd_en = wb_cyc & wb_stb & ~wb_we & ~wb_ack;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= strap_pkg::CTRL_RESET;
    end else if (wr_en && wb_adr == strap_pkg::OFS_CTRL && wb_sel[0]) begin
      ctrl_q <= wb_dat_w[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      gpio_oe_q <= strap_pkg::GPIO_OE_RESET;
    end else if (wr_en && wb_adr == strap_pkg::OFS_GPIO_OE) begin
      gpio_oe_q <= merge_byte(gpio_oe_q, wb_dat_w[7:0], wb_sel[0]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      gpio_out_q <= strap_pkg::GPIO_OUT_RESET;
    end else if (wr_en && wb_adr == strap_pkg::OFS_GPIO_OUT) begin
      gpio_out_q <= merge_byte(gpio_out_q, wb_dat_w[7:0], wb_sel[0]);
    end
  end

  // ************************************************************
  // gpio direction and pin reuse
  // ************************************************************
  logic smb_en;
  logic [7:0] pin_mask;

  assign smb_en = ctrl_q[strap_pkg::CT_SMB_EN];

  always_comb begin
    pin_mask = 8'hFF;
    if (smb_en) begin
      pin_mask[7:5] = 3'b000;
    end
    if (debug_mode) begin
      pin_mask[4:0] = 5'b0_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      gpio_drv <= 8'h00;
      gpio_oe_n <= 8'hFF;
    end else begin
      gpio_drv <= gpio_out_q;
      gpio_oe_n <= ~(gpio_oe_q & pin_mask);
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      smbus_addr_low <= 3'b000;
    end else if (smb_en) begin
      smbus_addr_low <= gpio_sync[7:5];
    end else begin
      smbus_addr_low <= 3'b000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      debug_select <= 5'b0_0000;
    end else if (debug_mode) begin
      debug_select <= gpio_sync[4:0];
    end else begin
      debug_select <= 5'b0_0000;
    end
  end

  // ************************************************************
  // port status pins
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      port_status <= 3'b000;
    end else if (debug_mode && !pso_en_q) begin
      port_status <= 3'b000;
    end else begin
      port_status <= link_status;
    end
  end

  // ************************************************************
  // full scan enable pin
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scan_en_drv <= 1'b0;
      scan_en_oe_n <= 1'b0;
      scan_en_sample <= 1'b0;
    end else if (mfg_q) begin
      scan_en_drv <= 1'b0;
      scan_en_oe_n <= 1'b1;
      scan_en_sample <= scan_sync;
    end else begin
      scan_en_drv <= 1'b0;
      scan_en_oe_n <= 1'b0;
      scan_en_sample <= 1'b0;
    end
  end

  // ************************************************************
  // eeprom pins
  // ************************************************************
  eeprom_pins u_eeprom (
    .clk(clk),
    .rstn(rstn),
    .active(ctrl_q[strap_pkg::CT_EE_ACTIVE]),
    .data_bit(ctrl_q[strap_pkg::CT_EE_DATA]),
    .release_line(ctrl_q[strap_pkg::CT_EE_RELEASE]),
    .eeprom_clk(eeprom_clk),
    .sdio_drv(eeprom_sdio_drv),
    .sdio_oe_n(eeprom_sdio_oe_n)
  );

  // ************************************************************
  // read mux
  // ************************************************************
  logic [8:0] strap_word;
  logic [5:0] ctrl_word;
  logic [31:0] rd_mux;

  always_comb begin
    strap_word = 9'h000;
    strap_word[strap_pkg::ST_PRESENT_LSB +: 2] = device_present;
    strap_word[strap_pkg::ST_REFCLK] = refclk_shared;
    strap_word[strap_pkg::ST_SLOT_LSB +: 2] = slot_connected;
    strap_word[strap_pkg::ST_PWR_SAVE] = power_saving_en;
    strap_word[strap_pkg::ST_DEBUG] = debug_mode;
    strap_word[strap_pkg::ST_PSO_EN] = pso_en_q;
    strap_word[strap_pkg::ST_MFG_TEST] = mfg_q;
  end

  always_comb begin
    ctrl_word = {2'b00, ctrl_q};
    ctrl_word[strap_pkg::CT_EE_PIN] = sdio_sync;
    ctrl_word[strap_pkg::CT_EE_CLK] = eeprom_clk;
  end

  always_comb begin
    case (wb_adr)
      strap_pkg::OFS_STRAP_STATUS: rd_mux = {23'h00_0000, strap_word};
      strap_pkg::OFS_GPIO_OE: rd_mux = byte_word(gpio_oe_q);
      strap_pkg::OFS_GPIO_OUT: rd_mux = byte_word(gpio_out_q);
      strap_pkg::OFS_GPIO_IN: rd_mux = byte_word(gpio_sync);
      strap_pkg::OFS_CTRL: rd_mux = {26'h000_0000, ctrl_word};
      strap_pkg::OFS_SMB_ADDR: rd_mux = {29'h0000_0000, smbus_addr_low};
      strap_pkg::OFS_DEBUG_SEL: rd_mux = {27'h000_0000, debug_select};
      strap_pkg::OFS_PORT_STATUS: rd_mux = {29'h0000_0000, port_status};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // wishbone answer, one wait state
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_ack <= 1'b0;
    end else begin
      wb_ack <= wb_cyc & wb_stb & ~wb_ack;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_dat_r <= 32'h0000_0000;
    end else if (rd_en) begin
      wb_dat_r <= rd_mux;
    end
  end

endmodule

// *** verification/strap_properties.sv ***
// assertion checker for the strap and debug pin block
module strap_checker (
  // clock and reset
  input logic clk,
  input logic rstn,
  // wishbone handshake
  input logic wb_cyc,
  input logic wb_stb,
  input logic wb_ack,
  // link status input and decoded outputs
  input logic [2:0] link_status,
  input logic [2:1] device_present,
  input logic refclk_shared,
  input logic [2:1] slot_connected,
  input logic power_saving_en,
  input logic debug_mode,
  input logic [2:0] smbus_addr_low,
  input logic [4:0] debug_select,
  input logic [2:0] port_status,
  // pins
  input logic eeprom_clk,
  input logic scan_en_drv,
  input logic scan_en_oe_n,
  input logic [7:0] gpio_pin,
  input logic [7:0] gpio_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev_q;
  logic [9:0] half_q;
  // cycles since the eeprom clock last changed, saturating
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_q <= 1'b0;
      half_q <= 10'h000;
    end else begin
      prev_q <= eeprom_clk;
      if (eeprom_clk != prev_q) begin
        half_q <= 10'h000;
      end else if (half_q != 10'h3ff) begin
        half_q <= half_q + 10'h001;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ********
  // sequences and properties
  // ********
  sequence s_req;
    wb_cyc && wb_stb && !wb_ack;
  endsequence
  sequence s_run;
    rstn [*4];
  endsequence
  property p_ack;
    s_req |=> wb_ack;
  endproperty
  property p_ack_one;
    wb_ack |=> !wb_ack;
  endproperty
  property p_scan_drv;
    !scan_en_drv;
  endproperty
  property p_hold;
    s_run |-> $stable({device_present, refclk_shared, slot_connected,
      power_saving_en, debug_mode, scan_en_oe_n});
  endproperty
  property p_status;
    $past(rstn) && !$past(debug_mode) |-> port_status == $past(link_status);
  endproperty
  property p_ee_half;
    $rose(eeprom_clk) |-> half_q >= 10'h0f0;
  endproperty
  property p_smb;
    $past(rstn) |-> smbus_addr_low == 3'h0 ||
      smbus_addr_low == $past(gpio_pin[7:5], 3);
  endproperty
  property p_dbg;
    $past(rstn) |-> debug_select ==
      ($past(debug_mode) ? $past(gpio_pin[4:0], 3) : 5'h00);
  endproperty
  property p_mask;
    debug_mode && $past(debug_mode) |-> &gpio_oe_n[4:0];
  endproperty
  a_ack: assert property (p_ack)
    else $error("no ack one cycle after request");
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");
  a_scan_drv: assert property (p_scan_drv)
    else $error("scan enable driven high");
  a_hold: assert property (p_hold)
    else $error("latched strap changed after release");
  a_status: assert property (p_status)
    else $error("port status does not follow link status");
  a_ee_half: assert property (p_ee_half)
    else $error("eeprom clock half period too short");
  a_smb: assert property (p_smb)
    else $error("smbus address bits not from gpio");
  a_dbg: assert property (p_dbg)
    else $error("debug select not from gpio");
  a_mask: assert property (p_mask)
    else $error("debug select gpio driven in debug mode");
endmodule

bind port_strap_debug_config strap_checker strap_checker_i (.clk, .rstn,
  .wb_cyc, .wb_stb, .wb_ack, .link_status, .device_present,
  .refclk_shared, .slot_connected, .power_saving_en, .debug_mode,
  .smbus_addr_low, .debug_select, .port_status, .eeprom_clk,
  .scan_en_drv, .scan_en_oe_n, .gpio_pin, .gpio_oe_n);

// *** verification/board_model.sv ***
// board straps, debug header and eeprom data line
module board_model (
  // settings from the bench
  input wire logic [8:0] strap_set,
  input wire logic [7:0] gpio_ext,
  input wire logic ee_ext,
  input wire logic scan_ext,
  // device pin drivers
  input wire logic eeprom_sdio_drv,
  input wire logic eeprom_sdio_oe_n,
  input wire logic scan_en_drv,
  input wire logic scan_en_oe_n,
  input wire logic [7:0] gpio_drv,
  input wire logic [7:0] gpio_oe_n,
  // pins seen by the device
  output logic [2:1] slot_presence_n,
  output logic shared_refclk_sel,
  output logic [2:1] slot_implemented,
  output logic power_saving_strap,
  output logic debug_mode_enable_n,
  output logic port_state_out_enable,
  output logic mfg_test_mode,
  output logic eeprom_sdio_pin,
  output logic scan_en_pin,
  output logic [7:0] gpio_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  assign slot_presence_n = strap_set[1:0];
  assign shared_refclk_sel = strap_set[2];
  assign slot_implemented = strap_set[4:3];
  assign power_saving_strap = strap_set[5];
  assign debug_mode_enable_n = strap_set[6];
  assign port_state_out_enable = strap_set[7];
  assign mfg_test_mode = strap_set[8];
  // released data line shows the eeprom side
  assign eeprom_sdio_pin = eeprom_sdio_oe_n ? ee_ext : eeprom_sdio_drv;
  assign scan_en_pin = scan_en_oe_n ? scan_ext : scan_en_drv;
  // device level where driven, header level elsewhere
  assign gpio_pin = (gpio_drv & ~gpio_oe_n) | (gpio_ext & gpio_oe_n);
endmodule

// *** verification/port_strap_debug_config_test.sv ***
// testbench for the strap and debug pin block
module port_strap_debug_config_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [8:0] pin;
    logic [8:0] stat;
  } row_type;
  row_type rows [4] = '{'{9'h043, 9'h000}, '{9'h06e, 9'h02d},
    '{9'h111, 9'h152}, '{9'h09c, 9'h0df}};
  logic clk, rstn, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [31:0] wb_dat_w, wb_dat_r, rd;
  logic [3:0] wb_sel;
  logic [2:1] slot_presence_n, slot_implemented, device_present;
  logic [2:1] slot_connected;
  logic shared_refclk_sel, power_saving_strap, port_state_out_enable;
  logic debug_mode_enable_n, mfg_test_mode, refclk_shared;
  logic power_saving_en, debug_mode, scan_en_sample, eeprom_clk;
  logic eeprom_sdio_pin, eeprom_sdio_drv, eeprom_sdio_oe_n;
  logic scan_en_pin, scan_en_drv, scan_en_oe_n, ee_ext, scan_ext;
  logic [2:0] link_status, smbus_addr_low, port_status;
  logic [4:0] debug_select;
  logic [7:0] gpio_pin, gpio_drv, gpio_oe_n, gpio_ext;
  logic [8:0] strap_set, st;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc_count = 0;
  int n;
  port_strap_debug_config port_strap_debug_config_i (.clk, .rstn,
    .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_dat_w, .wb_sel, .wb_dat_r,
    .wb_ack, .slot_presence_n, .shared_refclk_sel, .slot_implemented,
    .power_saving_strap, .port_state_out_enable, .debug_mode_enable_n,
    .mfg_test_mode, .link_status, .device_present, .refclk_shared,
    .slot_connected, .power_saving_en, .debug_mode, .smbus_addr_low,
    .debug_select, .scan_en_sample, .port_status, .eeprom_clk,
    .eeprom_sdio_pin, .eeprom_sdio_drv, .eeprom_sdio_oe_n, .scan_en_pin,
    .scan_en_drv, .scan_en_oe_n, .gpio_pin, .gpio_drv, .gpio_oe_n);
  board_model board_model_i (.strap_set, .gpio_ext, .ee_ext, .scan_ext,
    .eeprom_sdio_drv, .eeprom_sdio_oe_n, .scan_en_drv, .scan_en_oe_n,
    .gpio_drv, .gpio_oe_n, .slot_presence_n, .shared_refclk_sel,
    .slot_implemented, .power_saving_strap, .debug_mode_enable_n,
    .port_state_out_enable, .mfg_test_mode, .eeprom_sdio_pin,
    .scan_en_pin, .gpio_pin);
  always #10 clk = ~clk;
  // ********
  // tasks
  // ********
  task automatic close_out;
    $display("mismatches %0d of %0d compares", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr,
    input logic [31:0] dat, input logic [3:0] sel);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= dat;
    wb_sel <= sel;
    do @(posedge clk); while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, dat, 4'h1);
  endtask
  task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000, 4'h1);
    chk(rd, exp);
  endtask
  task automatic do_reset(input logic [8:0] pins);
    strap_set <= pins;
    rstn <= 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc_count++;
    if (cyc_count >= 20000) begin
      bad_count++;
      close_out();
    end
  end
  // ********
  // main sequence
  // ********
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_dat_w = 32'h0000_0000;
    wb_sel = 4'h0;
    strap_set = 9'h043;
    gpio_ext = 8'hd3;
    ee_ext = 1'b1;
    scan_ext = 1'b1;
    link_status = 3'h5;
    for (int i = 0; i < 4; i++) begin
      do_reset(rows[i].pin);
      st = rows[i].stat;
      chk({scan_en_sample, scan_en_drv, scan_en_oe_n, debug_mode,
        power_saving_en, slot_connected, refclk_shared, device_present},
        {st[8], 1'b0, st[8], st[6:0]});
      rdc(strap_pkg::OFS_STRAP_STATUS, {23'h0, st});
      chk(port_status, (st[6] && !st[7]) ? 3'h0 : 3'h5);
      chk(debug_select, st[6] ? 5'h13 : 5'h00);
    end
    // straps changed after release are ignored, status bits kept apart
    strap_set <= 9'h043;
    link_status <= 3'h6;
    rdc(strap_pkg::OFS_PORT_STATUS, 32'h0000_0006);
    chk(port_status, 3'h6);
    rdc(strap_pkg::OFS_DEBUG_SEL, 32'h0000_0013);
    rdc(strap_pkg::OFS_STRAP_STATUS, 32'h0000_00df);
    // gpio direction, readback and refused accesses
    wr(strap_pkg::OFS_GPIO_OE, 32'h0000_00ff);
    wr(strap_pkg::OFS_GPIO_OUT, 32'h0000_00a5);
    wb(1'b1, strap_pkg::OFS_GPIO_OE, 32'h0000_0000, 4'h0);
    rdc(strap_pkg::OFS_GPIO_OE, 32'h0000_00ff);
    rdc(8'h20, 32'h0000_0000);
    chk(gpio_oe_n, 8'h1f);
    chk(gpio_drv, 8'ha5);
    rdc(strap_pkg::OFS_GPIO_IN, 32'h0000_00b3);
    // smbus address from gpio
    wr(strap_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (6) @(posedge clk);
    chk(gpio_oe_n, 8'hff);
    chk(smbus_addr_low, 3'h6);
    rdc(strap_pkg::OFS_SMB_ADDR, 32'h0000_0006);
    // eeprom clock and data line
    wr(strap_pkg::OFS_CTRL, 32'h0000_0003);
    n = 0;
    while (eeprom_clk !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk(n > 240 && n < 260, 1'b1);
    chk({eeprom_sdio_oe_n, eeprom_sdio_drv, eeprom_sdio_pin}, 3'h0);
    ee_ext <= 1'b0;
    wr(strap_pkg::OFS_CTRL, 32'h0000_000f);
    repeat (2) @(posedge clk);
    chk({eeprom_sdio_oe_n, eeprom_sdio_drv, eeprom_sdio_pin}, 3'h6);
    wr(strap_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk({eeprom_clk, eeprom_sdio_oe_n, eeprom_sdio_drv}, 3'h1);
    rdc(strap_pkg::OFS_CTRL, 32'h0000_0011);
    close_out();
  end
endmodule
